// ===== design/cptf_pkg.sv
// Constants, register layouts and carrier types for the core control block.
// Assumes a single 50 MHz system clock and byte-wide register access.
package cptf_pkg;
    // Register offsets
    localparam logic [7:0] PRIO_OFS     = 8'hB8;
    localparam logic [7:0] STROBE_OFS   = 8'hBE;
    localparam logic [7:0] CACHE_OFS    = 8'hE3;
    localparam logic [7:0] PAGE_OFS     = 8'hA7;
    localparam logic [7:0] CFG_PAGE     = 8'h0F;
    // Reset values
    localparam logic [7:0] PRIO_RST     = 8'h80;
    localparam logic [7:0] STROBE_RST   = 8'h0F;
    localparam logic [7:0] CACHE_RST    = 8'h20;
    localparam logic [7:0] PAGE_RST     = 8'h00;
    // Field positions
    localparam int PRIO_TOP_BIT  = 7;
    localparam int PF_EN_BIT     = 5;
    localparam int PAIR_WR_BIT   = 0;
    localparam int NUM_SRC       = 7;
    // Strobe timing
    localparam int STROBE_BASE_NS     = 5;
    localparam int STROBE_STEP_NS     = 5;
    localparam int SYS_CLK_KHZ        = 50000;
    localparam int SLOW_CLK_LIMIT_KHZ = 12500;
    localparam int MAX_CYCLES         = 8;

    // One instruction's length and duration
    typedef struct packed {
        logic [1:0] bytes;
        logic [3:0] cycles;
        logic       known;
    } cptf_timing_t;

    // Register access request
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic       bit_wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } cptf_sfr_req_t;
endpackage : cptf_pkg

// ===== design/cptf_timer.sv
// Instruction length and cycle sequencer.
// Assumes the fetch side presents one opcode per issue strobe.
`timescale 1ns/100ps
`default_nettype none
module cptf_timer #(
    parameter int MAX_CYC = cptf_pkg::MAX_CYCLES
) (
    input  wire logic                 ref_clk_in,    // System clock
    input  wire logic                 rst_n_in,      // Async reset, active low
    input  wire logic                 issue_in,      // Opcode valid
    input  wire logic [7:0]           opcode_in,     // First instruction byte
    output logic                      ready_out,     // May issue this cycle
    output logic                      done_out,      // Instruction completes
    output cptf_pkg::cptf_timing_t    timing_out     // Length of last issue
);
    initial
    begin
        if (MAX_CYC != cptf_pkg::MAX_CYCLES)
            $error("cptf_timer: cycle ceiling must stay at eight");
    end

    // Classify opcode into bytes and cycles
    function automatic cptf_pkg::cptf_timing_t decode(input logic [7:0] op);
        cptf_pkg::cptf_timing_t t;
        t = '{bytes: 2'd1, cycles: 4'd1, known: 1'b0};
        if (op[7:4] inside {4'h2, 4'h3, 4'h9, 4'h4, 4'h5, 4'h6})
        begin
            t.known = 1'b1;
            if (op[3])
                t = '{bytes: 2'd1, cycles: 4'd1, known: 1'b1};
            else if (op[3:1] == 3'b011)
                t = '{bytes: 2'd1, cycles: 4'd2, known: 1'b1};
            else if (op[3:0] == 4'h5)
                t = '{bytes: 2'd2, cycles: 4'd2, known: 1'b1};
            else if (op[3:0] == 4'h4)
                t = '{bytes: 2'd2, cycles: 4'd2, known: 1'b1};
            else if (op[3:0] == 4'h3 && op[7:4] != 4'h9)
                t = '{bytes: 2'd3, cycles: 4'd3, known: 1'b1};
            else if (op[3:0] == 4'h2 && op[7:4] != 4'h9)
                t = '{bytes: 2'd2, cycles: 4'd2, known: 1'b1};
            else
                t.known = 1'b0;
        end
        else if (op == 8'hA4)
            t = '{bytes: 2'd1, cycles: 4'd4, known: 1'b1};
        else if (op == 8'h84)
            t = '{bytes: 2'd1, cycles: 4'd8, known: 1'b1};
        return t;
    endfunction : decode

    typedef struct packed {
        logic [3:0]             cnt;
        logic                   done;
        cptf_pkg::cptf_timing_t tim;
    } cptf_tstate_t;

    cptf_tstate_t s_q;
    cptf_tstate_t s_d;

    // Countdown; a new issue is allowed in the final cycle
    always_comb
    begin
        s_d      = s_q;
        s_d.done = (s_q.cnt == 4'd1);
        if (s_q.cnt != 4'd0)
            s_d.cnt = s_q.cnt - 4'd1;
        if (issue_in && ready_out)
        begin
            s_d.tim = decode(opcode_in);
            s_d.cnt = s_d.tim.cycles;
        end
    end

    // State register
    always_ff @(posedge ref_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            s_q <= '{cnt: 4'd0, done: 1'b0, tim: '{bytes: 2'd1, cycles: 4'd1, known: 1'b0}};
        else
            s_q <= s_d;
    end

    assign ready_out  = (s_q.cnt <= 4'd1);
    assign done_out   = s_q.done;
    assign timing_out = s_q.tim;

    // Checks
    sequence issue_2cyc;
        issue_in && ready_out && s_d.tim.cycles == 4'd2;
    endsequence

    a_cycle_ceiling: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        s_q.cnt <= 4'd8) else $error("cycle count above eight");
    a_two_cycle_done: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        issue_2cyc |=> (s_q.cnt == 4'd2) ##1 !done_out ##1 done_out)
        else $error("two-cycle op timing wrong");
    a_reg_one_cycle: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        (issue_in && ready_out && opcode_in == 8'h28) |=> (s_q.cnt == 4'd1 && timing_out.bytes == 2'd1))
        else $error("register add not single cycle");
    a_imm_logic_len: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        (issue_in && ready_out && opcode_in == 8'h53) |=> (timing_out.bytes == 2'd3 ##3 done_out))
        else $error("immediate-to-direct logic timing wrong");
endmodule : cptf_timer
`default_nettype wire

// ===== design/cptf_core_ctrl.sv
// Core control: page stack, interrupt priority, cache and flash strobe
// registers, and instruction timing through the sequencer.
// Assumes register requests and interrupt lines are synchronous to the clock.
`timescale 1ns/100ps
`default_nettype none
module cptf_core_ctrl #(
    parameter int NSRC = cptf_pkg::NUM_SRC
) (
    input  wire logic                 ref_clk_in,       // System clock
    input  wire logic                 rst_n_in,         // Async reset, active low
    input  wire cptf_pkg::cptf_sfr_req_t sfr_req_in,    // Register access
    input  wire logic [2:0]           bit_sel_in,       // Bit number for bit write
    output logic [7:0]                sfr_rdata_out,    // Read data, registered
    output logic                      sfr_hit_out,      // Last read was mapped
    input  wire logic                 issue_in,         // Opcode valid
    input  wire logic [7:0]           opcode_in,        // Opcode
    output logic                      ready_out,        // Sequencer can accept
    output logic                      done_out,         // Instruction done
    output cptf_pkg::cptf_timing_t    timing_out,       // Bytes and cycles
    input  wire logic [NSRC-1:0]      irq_req_in,       // Pending sources
    input  wire logic [NSRC*8-1:0]    irq_page_in,      // Page of each source
    input  wire logic                 reti_in,          // Handler return
    output logic                      irq_take_out,     // Vector taken pulse
    output logic [2:0]                irq_idx_out,      // Source taken
    output logic [7:0]                active_register_page_out, // Current page
    output logic [7:0]                saved_page_slot_out, // Pushed page
    output logic                      prefetch_enable_bit_out, // Prefetch on
    output logic                      flash_pair_write_enable_out, // Pair writes
    input  wire logic                 flash_read_timing_select_in, // Timing bit
    output logic                      strobe_limit_active_out, // Cap in force
    output logic [6:0]                strobe_max_ns_out, // Strobe cap in ns
    output logic                      flash_low_power_out // Idle after strobe
);
    initial
    begin
        if (NSRC != cptf_pkg::NUM_SRC)
            $error("cptf_core_ctrl: exactly seven sources supported");
    end

    typedef struct packed {
        logic [7:0] page;
        logic [7:0] next;
        logic [7:0] next2;
        logic [6:0] prio;
        logic       pf_en;
        logic       pair_wr;
        logic [3:0] period;
        logic       in_hi;
        logic       in_lo;
        logic       lo_under_hi;
        logic [7:0] rdata;
        logic       hit;
        logic       take;
        logic [2:0] idx;
    } cptf_state_t;

    cptf_state_t s_q;
    cptf_state_t s_d;

    // Register visible at the current page
    function automatic logic mapped(input logic [7:0] a, input logic [7:0] pg);
        return (a == cptf_pkg::PRIO_OFS) || (a == cptf_pkg::PAGE_OFS) ||
               (pg == cptf_pkg::CFG_PAGE &&
                (a == cptf_pkg::STROBE_OFS || a == cptf_pkg::CACHE_OFS));
    endfunction : mapped

    // Lowest numbered pending source within a mask
    function automatic logic [3:0] pick(input logic [NSRC-1:0] m);
        logic [3:0] r;
        r = 4'h8;
        for (int i = NSRC - 1; i >= 0; i--)
            if (m[i])
                r = 4'(i);
        return r;
    endfunction : pick

    logic [NSRC-1:0] hi_pend;
    logic [NSRC-1:0] lo_pend;
    logic [3:0]      hi_sel;
    logic [3:0]      lo_sel;
    logic            core_idle;

    // Split pending sources by level
    assign hi_pend = irq_req_in & s_q.prio;
    assign lo_pend = irq_req_in & ~s_q.prio;
    assign hi_sel  = pick(hi_pend);
    assign lo_sel  = pick(lo_pend);

    // Next state
    always_comb
    begin
        logic [7:0] wv;
        logic       can_hi;
        logic       can_lo;
        wv        = 8'h00;
        s_d       = s_q;
        s_d.take  = 1'b0;
        can_hi    = core_idle && !s_q.in_hi && hi_sel != 4'h8;
        can_lo    = core_idle && !s_q.in_hi && !s_q.in_lo && lo_sel != 4'h8;
        // Register reads
        if (sfr_req_in.rd)
        begin
            s_d.hit   = mapped(sfr_req_in.addr, s_q.page);
            s_d.rdata = 8'h00;
            if (sfr_req_in.addr == cptf_pkg::PRIO_OFS)
                s_d.rdata = {1'b1, s_q.prio};
            else if (sfr_req_in.addr == cptf_pkg::PAGE_OFS)
                s_d.rdata = s_q.page;
            else if (s_d.hit && sfr_req_in.addr == cptf_pkg::STROBE_OFS)
                s_d.rdata = {4'h0, s_q.period};
            else if (s_d.hit)
                s_d.rdata = {2'b00, s_q.pf_en, 4'h0, s_q.pair_wr};
        end
        // Byte and bit writes to the priority register
        if (sfr_req_in.addr == cptf_pkg::PRIO_OFS && (sfr_req_in.wr || sfr_req_in.bit_wr))
        begin
            wv = {1'b1, s_q.prio};
            if (sfr_req_in.wr)
                wv = sfr_req_in.wdata;
            else
                wv[bit_sel_in] = sfr_req_in.wdata[0];
            s_d.prio = wv[6:0];
        end
        // Page register, writable from any page; a return or vector entry in the same cycle wins
        if (sfr_req_in.wr && sfr_req_in.addr == cptf_pkg::PAGE_OFS)
            s_d.page = sfr_req_in.wdata;
        // Configuration page registers
        if (sfr_req_in.wr && s_q.page == cptf_pkg::CFG_PAGE)
        begin
            if (sfr_req_in.addr == cptf_pkg::CACHE_OFS)
            begin
                s_d.pf_en   = sfr_req_in.wdata[cptf_pkg::PF_EN_BIT];
                s_d.pair_wr = sfr_req_in.wdata[cptf_pkg::PAIR_WR_BIT];
            end
            if (sfr_req_in.addr == cptf_pkg::STROBE_OFS)
                s_d.period = sfr_req_in.wdata[3:0];
        end
        // Handler return pops one level
        if (reti_in && (s_q.in_hi || s_q.in_lo))
        begin
            s_d.page  = s_q.next;
            s_d.next  = s_q.next2;
            if (s_q.in_hi)
            begin
                s_d.in_hi = 1'b0;
                s_d.in_lo = s_q.lo_under_hi;
                s_d.lo_under_hi = 1'b0;
            end
            else
                s_d.in_lo = 1'b0;
        end
        // Vector entry pushes the page; entry wins over a page write
        else if (can_hi || can_lo)
        begin
            s_d.take  = 1'b1;
            s_d.idx   = can_hi ? hi_sel[2:0] : lo_sel[2:0];
            s_d.next2 = s_q.next;
            s_d.next  = s_q.page;
            s_d.page  = irq_page_in[8*(can_hi ? hi_sel[2:0] : lo_sel[2:0]) +: 8];
            if (can_hi)
            begin
                s_d.in_hi = 1'b1;
                s_d.lo_under_hi = s_q.in_lo;
                s_d.in_lo = 1'b0;
            end
            else
                s_d.in_lo = 1'b1;
        end
    end

    // State register
    always_ff @(posedge ref_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            s_q         <= '0;
            s_q.page    <= cptf_pkg::PAGE_RST;
            s_q.prio    <= cptf_pkg::PRIO_RST[6:0];
            s_q.pf_en   <= cptf_pkg::CACHE_RST[cptf_pkg::PF_EN_BIT];
            s_q.pair_wr <= cptf_pkg::CACHE_RST[cptf_pkg::PAIR_WR_BIT];
            s_q.period  <= cptf_pkg::STROBE_RST[3:0];
        end
        else
            s_q <= s_d;
    end

    // Instruction length and cycle sequencer
    cptf_timer #(
        .MAX_CYC (cptf_pkg::MAX_CYCLES)
    ) u_timer (
        .ref_clk_in (ref_clk_in),
        .rst_n_in   (rst_n_in),
        .issue_in   (issue_in),
        .opcode_in  (opcode_in),
        .ready_out  (ready_out),
        .done_out   (done_out),
        .timing_out (timing_out)
    );

    // Interrupts vector only between instructions
    assign core_idle = ready_out && !issue_in;

    // Flash strobe limit; ignored on a fast clock with the timing bit clear
    localparam logic SLOW_CLK = (cptf_pkg::SYS_CLK_KHZ <= cptf_pkg::SLOW_CLK_LIMIT_KHZ);
    assign strobe_limit_active_out = SLOW_CLK || flash_read_timing_select_in;
    assign strobe_max_ns_out = 7'(cptf_pkg::STROBE_BASE_NS)
                             + 7'(s_q.period) * 7'(cptf_pkg::STROBE_STEP_NS);
    assign flash_low_power_out = strobe_limit_active_out;

    // Outputs from the state register
    assign sfr_rdata_out               = s_q.rdata;
    assign sfr_hit_out                 = s_q.hit;
    assign irq_take_out                = s_q.take;
    assign irq_idx_out                 = s_q.idx;
    assign active_register_page_out    = s_q.page;
    assign saved_page_slot_out         = s_q.next;
    assign prefetch_enable_bit_out     = s_q.pf_en;
    assign flash_pair_write_enable_out = s_q.pair_wr;

    // Checks
    sequence page_write_s;
        sfr_req_in.wr && sfr_req_in.addr == cptf_pkg::PAGE_OFS && !reti_in && !s_d.take;
    endsequence

    sequence take_s;
        s_d.take;
    endsequence

    a_page_push_save: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        take_s |=> saved_page_slot_out == $past(s_q.page)) else $error("page not pushed");
    a_page_write_any: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        page_write_s |=> active_register_page_out == $past(sfr_req_in.wdata))
        else $error("page write lost");
    a_prio_top_one: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        (sfr_req_in.rd && sfr_req_in.addr == cptf_pkg::PRIO_OFS) |=> sfr_rdata_out[7])
        else $error("priority top bit not one");
    a_hi_no_nest: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        s_q.in_hi && !reti_in |=> !irq_take_out) else $error("vector taken during high");
    a_strobe_cap_ns: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        strobe_max_ns_out == 7'd5 + 7'd5 * 7'(s_q.period)) else $error("strobe cap wrong");
    a_fast_no_limit: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        !flash_read_timing_select_in |-> !strobe_limit_active_out)
        else $error("period active on fast clock");
endmodule : cptf_core_ctrl
`default_nettype wire

// ===== test/cptf_irq_model.sv
// Interrupting peripherals: each request holds until the core vectors to it.
// Assumes take pulse and index come from the core control block.
`timescale 1ns/100ps
`default_nettype none
module cptf_irq_model (
    input  wire logic        clk_in,   // System clock
    input  wire logic        rst_n_in, // Async reset, active low
    input  wire logic [6:0]  raise_in, // Bench raises sources
    input  wire logic        take_in,  // Vector taken pulse
    input  wire logic [2:0]  idx_in,   // Source taken
    output logic      [6:0]  req_out,  // Pending sources
    output logic      [55:0] page_out  // Register page of each source
);
    // Source i keeps its registers on page 0x10 plus i
    always_comb
    begin
        for (int i = 0; i < 7; i++)
            page_out[i*8 +: 8] = 8'h10 + 8'(i);
    end
    // Flag set on raise, cleared once the core has vectored to it
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            req_out <= '0;
        else
            req_out <= (req_out | raise_in) & ~(take_in ? (7'h01 << idx_in) : 7'h00);
    end
endmodule : cptf_irq_model
`default_nettype wire

// ===== test/cptf_core_ctrl_bench.sv
// Self-checking bench: registers, instruction timing and interrupt entry.
// Assumes the peripheral model drives the interrupt requests.
`timescale 1ns/100ps
`default_nettype none
module cptf_core_ctrl_bench;
    logic                    clk = 1'b0, rst_n = 1'b0, issue = 1'b0, reti = 1'b0, frt = 1'b0;
    cptf_pkg::cptf_sfr_req_t req = '0;
    cptf_pkg::cptf_timing_t  tmg;
    logic [2:0]              bsel = '0, idx;
    logic [6:0]              raise = '0, irq_req, smax;
    logic [7:0]              opc = '0, rdata, page, saved;
    logic [55:0]             irq_page;
    logic                    hit, ready, done, take, pf, pw, lim, lowp, tk, rd_seen = 1'b0;
    logic [15:0]             e;
    logic [8:0]              rd_q[$];
    logic [3:0]              cy_q[$];
    logic [18:0]             ir_q[$];
    int                      at_q[$];
    int                      cyc = 0, fail_count = 0, num_checks = 0, left = 0;
    // Opcode, bytes, cycles
    logic [15:0] tbl [22] = '{16'h2811, 16'h2522, 16'h2612, 16'h2422, 16'h3522, 16'h3F11,
        16'h9712, 16'h9422, 16'h5522, 16'h4522, 16'h6522, 16'h5222, 16'h4222, 16'h6222,
        16'h5333, 16'h4333, 16'h6333, 16'h5612, 16'h4612, 16'h6712, 16'hA414, 16'h8418};

    cptf_core_ctrl dut_u (.ref_clk_in(clk), .rst_n_in(rst_n), .sfr_req_in(req),
        .bit_sel_in(bsel), .sfr_rdata_out(rdata), .sfr_hit_out(hit), .issue_in(issue),
        .opcode_in(opc), .ready_out(ready), .done_out(done), .timing_out(tmg),
        .irq_req_in(irq_req), .irq_page_in(irq_page), .reti_in(reti), .irq_take_out(take),
        .irq_idx_out(idx), .active_register_page_out(page), .saved_page_slot_out(saved),
        .prefetch_enable_bit_out(pf), .flash_pair_write_enable_out(pw),
        .flash_read_timing_select_in(frt), .strobe_limit_active_out(lim),
        .strobe_max_ns_out(smax), .flash_low_power_out(lowp));
    cptf_irq_model src_u (.clk_in(clk), .rst_n_in(rst_n), .raise_in(raise), .take_in(take),
        .idx_in(idx), .req_out(irq_req), .page_out(irq_page));

    // Clock and edge count
    always #10 clk = ~clk;
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        rd_seen <= req.rd;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    begin
        num_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("BAD t=%0t %s: got %0h expected %0h", $time, what, got, exp);
        end
    end
    endtask : chk

    task automatic wrap_up;
    begin
        $display("Counts: %0d compares, %0d mismatches", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    end
    endtask : wrap_up

    // One register access: kind is {wr, rd, bit_wr}; v is write data or expected read
    task automatic sfr(input logic [2:0] kind, input logic [7:0] a, input logic [8:0] v);
    begin
        @(posedge clk);
        #1;
        {req.wr, req.rd, req.bit_wr} = kind;
        req.addr = a;
        req.wdata = v[7:0];
        if (kind[1])
            rd_q.push_back(v);
        @(posedge clk);
        #1;
        req = '0;
    end
    endtask : sfr

    // Raise sources and return strobe for one cycle
    task automatic irq(input logic [6:0] r, input logic rt);
    begin
        @(posedge clk);
        #1;
        raise = r;
        reti = rt;
        @(posedge clk);
        #1;
        raise = '0;
        reti = 1'b0;
    end
    endtask : irq

    // Bounded wait until every expected vector and cycle count has been seen
    task automatic drain;
    begin
        for (int k = 0; k < 20 && (ir_q.size() > 0 || cy_q.size() > 0); k++)
            @(posedge clk);
        #1;
        chk(ir_q.size() + cy_q.size(), 0, "expected result missing");
    end
    endtask : drain

    // Result monitor: pops the oldest note as each result appears
    always @(negedge clk)
    begin
        if (rd_seen && rd_q.size() > 0)
            chk({hit, rdata}, rd_q.pop_front(), "read data");
        if (done === 1'b1)
        begin
            if (cy_q.size() == 0)
                chk(1, 0, "done without issue");
            else
                chk(cyc - at_q.pop_front(), cy_q.pop_front(), "cycle count");
        end
        if (take === 1'b1)
        begin
            if (ir_q.size() == 0)
                chk(1, 0, "vector not allowed");
            else
                chk({idx, page, saved}, ir_q.pop_front(), "vector entry");
        end
    end

    // Hang guard
    initial
    begin
        repeat (20000) @(posedge clk);
        fail_count++;
        $display("BAD t=%0t run did not finish", $time);
        wrap_up();
    end

    initial
    begin
        void'($urandom(5));
        repeat (8) @(posedge clk);
        #1;
        rst_n = 1'b1;
        sfr(3'b010, 8'hB8, 9'h180);
        sfr(3'b010, 8'hE3, 9'h000);   // Hidden off the config page
        sfr(3'b100, 8'hBE, 9'h003);   // Ignored on page 0
        sfr(3'b010, 8'h12, 9'h000);   // Unmapped address
        sfr(3'b100, 8'hA7, 9'h00F);
        sfr(3'b010, 8'hBE, 9'h10F);
        sfr(3'b010, 8'hE3, 9'h120);
        chk({pf, pw}, 2'b10, "cache reset levels");
        sfr(3'b100, 8'hE3, 9'h0FF);
        sfr(3'b010, 8'hE3, 9'h121);
        chk({pf, pw}, 2'b11, "cache set levels");
        sfr(3'b100, 8'hE3, 9'h000);
        chk({pf, pw}, 2'b00, "cache clear levels");
        sfr(3'b100, 8'hBE, 9'h0FA);
        sfr(3'b010, 8'hBE, 9'h10A);
        chk(lim, 1'b0, "limit at fast clock");
        frt = 1'b1;
        @(posedge clk);
        #1;
        chk({lim, lowp, smax}, {2'b11, 7'd55}, "strobe cap");
        sfr(3'b100, 8'hB8, 9'h000);
        sfr(3'b010, 8'hB8, 9'h180);
        bsel = 3'd1;
        sfr(3'b001, 8'hB8, 9'h001);
        sfr(3'b010, 8'hB8, 9'h182);
        $display("test registers done");
        // Random opcodes every cycle; those offered while busy are refused
        for (int n = 0; n < 80; n++)
        begin
            e = tbl[$urandom_range(21)];
            issue = 1'b1;
            opc = e[15:8];
            chk(ready, left <= 1, "ready");
            tk = ready;
            @(posedge clk);
            #1;
            left = (left > 0) ? left - 1 : 0;
            if (tk)
            begin
                left = e[3:0];
                at_q.push_back(cyc);
                cy_q.push_back(e[3:0]);
                chk(tmg, {e[5:4], e[3:0], 1'b1}, "timing");
            end
        end
        issue = 1'b0;
        drain();
        $display("test timing done");
        // Low entry, page rewrite, high preemption, low held back
        sfr(3'b100, 8'hA7, 9'h003);
        ir_q.push_back({3'd4, 8'h14, 8'h03});
        irq(7'h10, 1'b0);
        drain();
        sfr(3'b100, 8'hA7, 9'h007);
        sfr(3'b010, 8'hA7, 9'h107);
        ir_q.push_back({3'd1, 8'h11, 8'h07});
        irq(7'h03, 1'b0);
        drain();
        repeat (6) @(posedge clk);
        irq(7'h00, 1'b1);
        chk({page, saved}, 16'h0703, "return from high");
        repeat (6) @(posedge clk);
        ir_q.push_back({3'd0, 8'h10, 8'h03});
        irq(7'h00, 1'b1);
        drain();
        $display("test interrupts done");
        wrap_up();
    end
endmodule : cptf_core_ctrl_bench
`default_nettype wire
